// *** bench/cpu_exec_checker_properties.sv ***
// Port-level assertions for the execution core
module cpu_exec_checker #(
    parameter PC_WIDTH = 11
) (
    input wire i_clk,
    input wire i_reset_n,
    input wire [11:0] i_instr,
    input wire i_instr_valid,
    input wire [7:0] i_file_rdata,
    input wire [PC_WIDTH-1:0] i_stack_top,
    input wire [7:0] o_file_wdata,
    input wire o_file_we,
    input wire o_stack_pop,
    input wire [PC_WIDTH-1:0] o_pc,
    input wire [7:0] o_acc,
    input wire [7:0] o_status,
    input wire [7:0] o_option,
    input wire o_flush,
    input wire o_watchdog_clear,
    input wire o_sleeping
);
    timeunit 1ns;
    timeprecision 1ps;
    // Only words the core really accepts count as executed
    wire go = i_instr_valid && !o_sleeping && !o_flush;
    wire [5:0] op6 = i_instr[11:6];
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    a_jump_page: assert property (go && i_instr[11:9] == 3'h5 |=>
        o_flush && o_pc == {$past(o_status[6:5]), $past(i_instr[8:0])})
        else $error("jump target wrong");
    a_inc_zero: assert property (go && op6 == 6'h0A |=>
        o_status[2] == ($past(i_file_rdata) == 8'hFF))
        else $error("increment zero flag wrong");
    a_skip_flush: assert property (go && op6 == 6'h0F |=>
        o_flush == ($past(i_file_rdata) == 8'hFF) && $stable(o_status))
        else $error("skip on zero wrong");
    a_or_literal: assert property (go && i_instr[11:8] == 4'hD |=>
        o_acc == ($past(o_acc) | $past(i_instr[7:0])))
        else $error("or literal wrong");
    a_move_zero: assert property (go && op6 == 6'h08 |=>
        o_status[2] == ($past(i_file_rdata) == 8'h00))
        else $error("move zero flag wrong");
    a_option_load: assert property (go && i_instr == 12'h002 |=>
        o_option == $past(o_acc) && $stable(o_status))
        else $error("option load wrong");
    a_return_pop: assert property (go && i_instr[11:8] == 4'h8 |=>
        o_stack_pop && o_pc == $past(i_stack_top) &&
        o_acc == $past(i_instr[7:0]))
        else $error("return wrong");
    a_sleep_flags: assert property (go && i_instr == 12'h003 |=>
        o_status[4] && !o_status[3] && $stable(o_status[7]) &&
        o_watchdog_clear)
        else $error("sleep flags wrong");
    a_sub_borrow: assert property (go && op6 == 6'h02 |=>
        o_status[0] == ($past(i_file_rdata) >= $past(o_acc)))
        else $error("subtract carry wrong");
    a_store_write: assert property (go && i_instr[11:5] == 7'h01 |=>
        o_file_we && o_file_wdata == $past(o_acc) && $stable(o_status))
        else $error("store wrong");
    c_sleep: cover property (go && i_instr == 12'h003);
    c_skip: cover property (go && op6 == 6'h0F ##1 o_flush);
    c_return: cover property (go && i_instr[11:8] == 4'h8);
endmodule
bind cpu_instr_exec_subset cpu_exec_checker #(.PC_WIDTH(PC_WIDTH)) chk_i (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_instr(i_instr),
    .i_instr_valid(i_instr_valid),
    .i_file_rdata(i_file_rdata),
    .i_stack_top(i_stack_top),
    .o_file_wdata(o_file_wdata),
    .o_file_we(o_file_we),
    .o_stack_pop(o_stack_pop),
    .o_pc(o_pc),
    .o_acc(o_acc),
    .o_status(o_status),
    .o_option(o_option),
    .o_flush(o_flush),
    .o_watchdog_clear(o_watchdog_clear),
    .o_sleeping(o_sleeping)
);

// *** bench/tb_cpu_instr_exec_subset.sv ***
// Self-checking bench for the execution core
module tb_cpu_instr_exec_subset;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_reset_n = 0, i_instr_valid = 0, i_wake = 0;
    logic [11:0] i_instr = 0;
    logic [7:0] i_file_rdata = 0;
    logic [10:0] i_stack_top = 0;
    wire [4:0] o_file_addr;
    wire [7:0] o_file_wdata, o_acc, o_status, o_option;
    wire [10:0] o_pc;
    wire o_file_we, o_stack_pop, o_flush, o_watchdog_clear;
    wire o_sleeping, o_osc_halt;
    int errors = 0, check_count = 0;
    cpu_instr_exec_subset cpu_instr_exec_subset_i (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_instr(i_instr),
        .i_instr_valid(i_instr_valid),
        .i_file_rdata(i_file_rdata),
        .i_stack_top(i_stack_top),
        .i_wake(i_wake),
        .o_file_addr(o_file_addr),
        .o_file_wdata(o_file_wdata),
        .o_file_we(o_file_we),
        .o_stack_pop(o_stack_pop),
        .o_pc(o_pc),
        .o_acc(o_acc),
        .o_status(o_status),
        .o_option(o_option),
        .o_flush(o_flush),
        .o_watchdog_clear(o_watchdog_clear),
        .o_sleeping(o_sleeping),
        .o_osc_halt(o_osc_halt)
    );
    initial forever #4 i_clk = ~i_clk;
    task chk(input string n, input [11:0] got, input [11:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s exp %h got %h", n, exp, got);
        end
    endtask
    // One word per call; valid drops so no word lands in a flush slot
    task exec(input [11:0] ins, input [7:0] fd);
        @(negedge i_clk);
        i_instr = ins;
        i_file_rdata = fd;
        i_instr_valid = 1;
        @(negedge i_clk);
        i_instr_valid = 0;
    endtask
    task t_literal;
        exec(12'hC9A, 0);
        chk("acc", o_acc, 8'h9A);
        chk("status", o_status, 8'h18);
        exec(12'hD35, 0);
        chk("acc", o_acc, 8'hBF);
        exec(12'h002, 0);
        chk("option", o_option, 8'hBF);
        exec(12'h121, 8'h40);
        chk("wdata", o_file_wdata, 8'hFF);
        chk("acc", o_acc, 8'hBF);
    endtask
    task t_inc;
        exec(12'h2A1, 8'hFF);
        chk("we", o_file_we, 1);
        chk("wdata", o_file_wdata, 0);
        chk("zero", o_status[2], 1);
        exec(12'h3C1, 8'hFF);
        chk("flush", o_flush, 1);
        exec(12'h201, 8'h80);
        chk("acc", o_acc, 8'h80);
        chk("zero", o_status[2], 0);
        exec(12'h221, 8'h00);
        chk("zero", o_status[2], 1);
    endtask
    task t_sub_rot;
        exec(12'hC02, 0);
        exec(12'h081, 8'h01);
        chk("acc", o_acc, 8'hFF);
        chk("carry", o_status[0], 0);
        chk("nibble", o_status[1], 0);
        exec(12'h0A1, 8'hFF);
        chk("wdata", o_file_wdata, 8'h00);
        chk("carry", o_status[0], 1);
        chk("zero", o_status[2], 1);
        chk("nibble", o_status[1], 1);
        exec(12'h341, 8'hE6);
        chk("acc", o_acc, 8'hCD);
        exec(12'h301, 8'hE6);
        chk("acc", o_acc, 8'hF3);
        chk("carry", o_status[0], 0);
    endtask
    task t_branch;
        i_stack_top = 11'h123;
        exec(12'h877, 0);
        chk("pc", o_pc, 11'h123);
        chk("acc", o_acc, 8'h77);
        chk("pop", o_stack_pop, 1);
        exec(12'hA05, 0);
        chk("pc", o_pc, 11'h005);
        chk("flush", o_flush, 1);
        exec(12'h021, 0);
        chk("wdata", o_file_wdata, 8'h77);
        exec(12'h000, 0);
        chk("we", o_file_we, 0);
    endtask
    task t_sleep;
        exec(12'h003, 0);
        chk("timeout", o_status[4], 1);
        chk("powerdown", o_status[3], 0);
        chk("halt", o_osc_halt, 1);
        chk("wdclear", o_watchdog_clear, 1);
        exec(12'hC55, 0);
        chk("acc", o_acc, 8'h77);
        chk("sleeping", o_sleeping, 1);
        i_wake = 1;
        @(negedge i_clk);
        i_wake = 0;
        chk("sleeping", o_sleeping, 0);
        chk("halt", o_osc_halt, 0);
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge i_clk);
        i_reset_n = 1;
        t_literal();
        t_inc();
        t_sub_rot();
        t_branch();
        t_sleep();
        wrap_up();
    end
    initial begin
        repeat (500) @(posedge i_clk);
        errors++;
        wrap_up();
    end
endmodule

// *** rtl/cpu_instr_exec_subset.v ***
// Instruction execution core for a subset of a 12-bit instruction set
// What this block does
// - Jump loads upper counter bits from status page field; two cycles.
// - Increment file, result by destination bit, zero flag updated.
// - Increment and skip on zero flushes fetched word; no flags change.
// - OR literal into accumulator, zero flag updated, one cycle.
// - OR accumulator with file, result by destination bit, zero flag.
// - Move file to accumulator or back to same file.
// - Move file updates zero flag even when writing back.
// - Load option register from accumulator, flags untouched.
// - Return with literal: accumulator gets literal, counter pops stack.
// - Rotate left through carry, result by destination bit.
// - Rotate right through carry, result by destination bit.
// - Sleep sets timeout flag, clears powerdown flag, keeps wake flag.
// - Sleep clears watchdog counter and its prescaler.
// - After sleep the core halts with oscillator stopped.
// - Subtract accumulator from file, updates carry, nibble borrow, zero.
// - Subtract carry is inverted borrow: set when result non-negative.
`include "exec_subset_map.vh"
module cpu_instr_exec_subset #(
    parameter PC_WIDTH = 11
) (
    input wire i_clk,
    input wire i_reset_n,
    input wire [11:0] i_instr,
    input wire i_instr_valid,
    input wire [7:0] i_file_rdata,
    input wire [PC_WIDTH-1:0] i_stack_top,
    input wire i_wake,
    output wire [4:0] o_file_addr,
    output reg [7:0] o_file_wdata,
    output reg o_file_we,
    output reg o_stack_pop,
    output reg [PC_WIDTH-1:0] o_pc,
    output reg [7:0] o_acc,
    output reg [7:0] o_status,
    output reg [7:0] o_option,
    output reg o_flush,
    output reg o_watchdog_clear,
    output reg o_sleeping,
    output reg o_osc_halt
);

// ----------------------------------------------------------------
// Decode
// ----------------------------------------------------------------
wire [5:0] op6 = i_instr[11:6];
wire [3:0] op4 = i_instr[11:8];
wire dest_file = i_instr[5];
wire [7:0] lit = i_instr[7:0];
wire [7:0] fval = i_file_rdata;
wire carry_in = o_status[`ST_CARRY];
// Words in a flush slot or during sleep never reach the decoder
wire run = i_instr_valid && !o_sleeping && !o_flush;

wire is_nop = (i_instr == `OP_NOP);
wire is_option = (i_instr == `OP_OPTION);
wire is_sleep = (i_instr == `OP_SLEEP);
wire is_store = (i_instr[11:5] == `OP7_STORE);
wire is_jump = (i_instr[11:9] == `OP3_JUMP);
wire is_return = (op4 == `OP4_RETURN_WITH_LITERAL);
wire is_load_lit = (op4 == `OP4_LOADLIT);
wire is_or_lit = (op4 == `OP4_ORLIT);
wire is_inc = (op6 == `OP6_INC);
wire is_inc_skip = (op6 == `OP6_INCSZ);
wire is_or_file = (op6 == `OP6_OR_FILE);
wire is_move = (op6 == `OP6_MOVE);
wire is_rotl = (op6 == `OP6_RLF);
wire is_rotr = (op6 == `OP6_RRF);
wire is_sub = (op6 == `OP6_SUB);
// Opcodes that read a file and route by the destination bit
wire is_file_op = is_inc || is_inc_skip || is_or_file || is_move ||
    is_rotl || is_rotr || is_sub;

assign o_file_addr = i_instr[4:0];

// ----------------------------------------------------------------
// Arithmetic
// ----------------------------------------------------------------
wire [8:0] sum_inc = {1'b0, fval} + 9'h001;
// Adding the complement keeps bit 8 as the inverted borrow
wire [8:0] diff = {1'b0, fval} + {1'b0, ~o_acc} + 9'h001;
wire [4:0] ndiff = {1'b0, fval[3:0]} + {1'b0, ~o_acc[3:0]} + 5'h01;
wire [7:0] or_file_val = o_acc | fval;
wire [7:0] or_lit_val = o_acc | lit;
wire [7:0] rotl_val = {fval[6:0], carry_in};
wire [7:0] rotr_val = {carry_in, fval[7:1]};
wire [PC_WIDTH-1:0] pc_plus_one = o_pc + {{(PC_WIDTH-1){1'b0}}, 1'b1};

// ----------------------------------------------------------------
// File operations
// ----------------------------------------------------------------
reg [7:0] result;
reg set_zero;
reg set_carry;
reg carry_out;
reg set_nibble;

always @* begin
    result = fval;
    set_zero = 1'b0;
    set_carry = 1'b0;
    carry_out = carry_in;
    set_nibble = 1'b0;
    if (is_inc) begin
        result = sum_inc[7:0];
        set_zero = 1'b1;
    end else if (is_inc_skip) begin
        result = sum_inc[7:0];
    end else if (is_or_file) begin
        result = or_file_val;
        set_zero = 1'b1;
    end else if (is_move) begin
        result = fval;
        set_zero = 1'b1;
    end else if (is_rotl) begin
        result = rotl_val;
        set_carry = 1'b1;
        carry_out = fval[7];
    end else if (is_rotr) begin
        result = rotr_val;
        set_carry = 1'b1;
        carry_out = fval[0];
    end else if (is_sub) begin
        result = diff[7:0];
        set_zero = 1'b1;
        set_carry = 1'b1;
        carry_out = diff[8];
        set_nibble = 1'b1;
    end
end

// ----------------------------------------------------------------
// Status flags
// ----------------------------------------------------------------
reg [7:0] status_next;

always @* begin
    status_next = o_status;
    if (run && is_file_op) begin
        if (set_zero) begin
            status_next[`ST_ZERO] = (result == 8'h00);
        end
        if (set_carry) begin
            status_next[`ST_CARRY] = carry_out;
        end
        if (set_nibble) begin
            status_next[`ST_NIBBLE] = ndiff[4];
        end
    end
    if (run && is_or_lit) begin
        status_next[`ST_ZERO] = (or_lit_val == 8'h00);
    end
    if (run && is_sleep) begin
        status_next[`ST_TIMEOUT] = 1'b1;
        status_next[`ST_POWERDOWN] = 1'b0;
    end
    // Wake flag is owned by the port logic and only held here
    status_next[`ST_WAKE] = o_status[`ST_WAKE];
end

// ----------------------------------------------------------------
// Accumulator and option
// ----------------------------------------------------------------
reg [7:0] acc_next;
reg [7:0] option_next;

always @* begin
    acc_next = o_acc;
    option_next = o_option;
    if (run && is_load_lit) begin
        acc_next = lit;
    end
    if (run && is_return) begin
        acc_next = lit;
    end
    if (run && is_or_lit) begin
        acc_next = or_lit_val;
    end
    if (run && is_file_op && !dest_file) begin
        acc_next = result;
    end
    if (run && is_option) begin
        option_next = o_acc;
    end
end

// ----------------------------------------------------------------
// File write
// ----------------------------------------------------------------
reg we_next;
reg [7:0] wdata_next;

always @* begin
    we_next = 1'b0;
    wdata_next = o_file_wdata;
    if (run && is_store) begin
        we_next = 1'b1;
        wdata_next = o_acc;
    end
    if (run && is_file_op && dest_file) begin
        we_next = 1'b1;
        wdata_next = result;
    end
end

// ----------------------------------------------------------------
// Program counter
// ----------------------------------------------------------------
reg [PC_WIDTH-1:0] pc_next;
reg flush_next;
reg pop_next;

always @* begin
    pc_next = o_pc;
    flush_next = 1'b0;
    pop_next = 1'b0;
    if (o_sleeping) begin
        // Counter freezes so the core resumes at the next word
        pc_next = o_pc;
    end else if (o_flush) begin
        // The discarded word still used a fetch slot
        pc_next = pc_plus_one;
    end else if (run) begin
        pc_next = pc_plus_one;
        if (is_jump) begin
            pc_next = {o_status[`ST_PAGE_HI:`ST_PAGE_LO], i_instr[8:0]};
            flush_next = 1'b1;
        end else if (is_return) begin
            pc_next = i_stack_top;
            pop_next = 1'b1;
            flush_next = 1'b1;
        end else if (is_inc_skip) begin
            flush_next = (sum_inc[7:0] == 8'h00);
        end else if (is_nop) begin
            pc_next = pc_plus_one;
        end
    end
end

// ----------------------------------------------------------------
// Power
// ----------------------------------------------------------------
reg sleep_next;
reg wdog_next;

always @* begin
    sleep_next = o_sleeping;
    wdog_next = 1'b0;
    if (o_sleeping) begin
        if (i_wake) begin
            sleep_next = 1'b0;
        end
    end else if (run && is_sleep) begin
        wdog_next = 1'b1;
        sleep_next = 1'b1;
    end
end

// ----------------------------------------------------------------
// Datapath registers
// ----------------------------------------------------------------
always @(posedge i_clk) begin
    if (!i_reset_n) begin
        o_acc <= `ACC_RESET;
    end else begin
        o_acc <= acc_next;
    end
end

always @(posedge i_clk) begin
    if (!i_reset_n) begin
        o_status <= `STATUS_RESET;
    end else begin
        o_status <= status_next;
    end
end

always @(posedge i_clk) begin
    if (!i_reset_n) begin
        o_option <= `OPTION_RESET;
    end else begin
        o_option <= option_next;
    end
end

// ----------------------------------------------------------------
// Control registers
// ----------------------------------------------------------------
always @(posedge i_clk) begin
    if (!i_reset_n) begin
        o_pc <= `PC_RESET;
    end else begin
        o_pc <= pc_next;
    end
end

always @(posedge i_clk) begin
    if (!i_reset_n) begin
        o_flush <= 1'b0;
    end else begin
        o_flush <= flush_next;
    end
end

always @(posedge i_clk) begin
    if (!i_reset_n) begin
        o_stack_pop <= 1'b0;
    end else begin
        o_stack_pop <= pop_next;
    end
end

always @(posedge i_clk) begin
    if (!i_reset_n) begin
        o_file_we <= 1'b0;
    end else begin
        o_file_we <= we_next;
    end
end

always @(posedge i_clk) begin
    if (!i_reset_n) begin
        o_file_wdata <= 8'h00;
    end else begin
        o_file_wdata <= wdata_next;
    end
end

// ----------------------------------------------------------------
// Power registers
// ----------------------------------------------------------------
always @(posedge i_clk) begin
    if (!i_reset_n) begin
        o_sleeping <= 1'b0;
    end else begin
        o_sleeping <= sleep_next;
    end
end

always @(posedge i_clk) begin
    if (!i_reset_n) begin
        o_osc_halt <= 1'b0;
    end else begin
        o_osc_halt <= sleep_next;
    end
end

always @(posedge i_clk) begin
    if (!i_reset_n) begin
        o_watchdog_clear <= 1'b0;
    end else begin
        o_watchdog_clear <= wdog_next;
    end
end

endmodule

// *** rtl/exec_subset_map.vh ***
// Opcode patterns, status bit positions and reset values for the core
`ifndef EXEC_SUBSET_MAP_VH
`define EXEC_SUBSET_MAP_VH
// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define ST_CARRY 0
`define ST_NIBBLE 1
`define ST_ZERO 2
`define ST_POWERDOWN 3
`define ST_TIMEOUT 4
`define ST_PAGE_LO 5
`define ST_PAGE_HI 6
`define ST_WAKE 7
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define STATUS_RESET 8'h0018
`define ACC_RESET 8'h0000
`define OPTION_RESET 8'h00FF
`define PC_RESET 11'h07FF
`define STACK_RESET 11'h0000
// ----------------------------------------------------------------
// Opcode patterns
// ----------------------------------------------------------------
`define OP_NOP 12'h0000
`define OP_OPTION 12'h0002
`define OP_SLEEP 12'h0003
`define OP6_SUB 6'h02
`define OP6_OR_FILE 6'h04
`define OP6_MOVE 6'h08
`define OP6_INC 6'h0A
`define OP6_RRF 6'h0C
`define OP6_RLF 6'h0D
`define OP6_INCSZ 6'h0F
`define OP7_STORE 7'h01
`define OP4_RETURN_WITH_LITERAL 4'h8
`define OP4_LOADLIT 4'hC
`define OP4_ORLIT 4'hD
`define OP3_JUMP 3'h5
`endif
